/* logic/vnap_access_point.sv */
`timescale 1ns/1ps
// Contract
// - On contention, schedule bit 0 high grants local, low grants upstream.
// - Schedule rotates left by one after each contested cycle in which the output stage is free.
// - Alternating pattern gives local priority every second contest; it is the default.
// - One bit per nibble gives local priority every fourth contest.
// - All-ones pattern is illegal and replaced by the default.
// - Asynchronous active-low reset clears only the access-point interface.
// - Reset output toward fabric stays low; user logic ignores it.
// - Every transfer and every state change other than reset happens on the rising clock edge.
// - Transmit ready is high only while a new word can be taken.
// - Each word carries a 4-bit destination row and reaches that row.
// - Transmit start and end flags travel to the destination unchanged.
// - Transmit and receive data are 293 bits, 292 down to 0.
// - Receive valid is high exactly while receive data holds a word.
// - Each received word comes with the 4-bit row it originated from.
// - Receive start and end flags equal those the source supplied.
module vnap_access_point #(
	parameter logic [vnap_pkg::ROW_W-1:0] MY_ROW = vnap_pkg::ROW_DEFAULT,
	parameter logic [vnap_pkg::SCHED_W-1:0] SOUTHWARD_PRIORITY_PATTERN = vnap_pkg::SCHED_DEFAULT,
	parameter logic [vnap_pkg::SCHED_W-1:0] NORTHWARD_PRIORITY_PATTERN = vnap_pkg::SCHED_DEFAULT
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	output logic rst_out_n_o,
	// User transmit side
	output logic tx_ready_o,
	input wire logic tx_valid_i,
	input wire logic [vnap_pkg::ROW_W-1:0] tx_dest_i,
	input wire logic tx_sop_i,
	input wire logic tx_eop_i,
	input wire logic [vnap_pkg::DATA_W-1:0] tx_data_i,
	// User receive side
	input wire logic rx_ready_i,
	output logic rx_valid_o,
	output logic [vnap_pkg::ROW_W-1:0] rx_src_o,
	output logic rx_sop_o,
	output logic rx_eop_o,
	output logic [vnap_pkg::DATA_W-1:0] rx_data_o,
	// Column network, arriving from the node to the north
	input wire logic from_north_valid_i,
	input wire vnap_pkg::vnap_flit_type from_north_flit_i,
	output logic from_north_ready_o,
	// Column network, arriving from the node to the south
	input wire logic from_south_valid_i,
	input wire vnap_pkg::vnap_flit_type from_south_flit_i,
	output logic from_south_ready_o,
	// Column network, leaving toward the south
	output logic to_south_valid_o,
	output vnap_pkg::vnap_flit_type to_south_flit_o,
	input wire logic to_south_ready_i,
	// Column network, leaving toward the north
	output logic to_north_valid_o,
	output vnap_pkg::vnap_flit_type to_north_flit_o,
	input wire logic to_north_ready_i
);
	localparam int DC = vnap_pkg::DIR_COUNT;
	localparam int FLIT_W = $bits(vnap_pkg::vnap_flit_type);

	// Index d names the side a word arrives from; out[d] leaves on the opposite side.
	logic [DC-1:0] up_valid;
	vnap_pkg::vnap_flit_type up_flit [DC];
	logic [DC-1:0] out_ready;

	logic [DC-1:0] hold_valid_q;
	logic [DC-1:0] hold_ready_q;
	vnap_pkg::vnap_flit_type hold_flit_q [DC];
	logic [DC-1:0] hold_to_rx;
	logic [DC-1:0] hold_pass;
	logic [DC-1:0] hold_pop;

	logic [DC-1:0] out_valid_q;
	vnap_pkg::vnap_flit_type out_flit_q [DC];
	logic [vnap_pkg::SCHED_W-1:0] sched_q [DC];
	logic [DC-1:0] out_free;
	logic [DC-1:0] loc_want;
	logic [DC-1:0] contest;
	logic [DC-1:0] grant_loc;
	logic [DC-1:0] loc_go;

	logic loc_valid;
	logic loc_pop;
	logic loc_self;
	vnap_pkg::vnap_flit_type loc_flit;
	vnap_pkg::vnap_flit_type tx_flit;
	vnap_pkg::vnap_route_type loc_route;

	logic rx_free;
	logic rx_rr_q;
	logic [DC-1:0] rx_take_hold;
	logic rx_take_loc;
	logic rx_valid_q;
	vnap_pkg::vnap_flit_type rx_flit_q;
	vnap_pkg::vnap_flit_type rx_next;
	logic rst_out_n_q;

	assign up_valid[vnap_pkg::DIR_N] = from_north_valid_i;
	assign up_valid[vnap_pkg::DIR_S] = from_south_valid_i;
	assign up_flit[vnap_pkg::DIR_N] = from_north_flit_i;
	assign up_flit[vnap_pkg::DIR_S] = from_south_flit_i;
	assign out_ready[vnap_pkg::DIR_N] = to_south_ready_i;
	assign out_ready[vnap_pkg::DIR_S] = to_north_ready_i;
	assign from_north_ready_o = hold_ready_q[vnap_pkg::DIR_N];
	assign from_south_ready_o = hold_ready_q[vnap_pkg::DIR_S];
	assign to_south_valid_o = out_valid_q[vnap_pkg::DIR_N];
	assign to_south_flit_o = out_flit_q[vnap_pkg::DIR_N];
	assign to_north_valid_o = out_valid_q[vnap_pkg::DIR_S];
	assign to_north_flit_o = out_flit_q[vnap_pkg::DIR_S];

	// The source row is stamped on entry; the framing flags pass through untouched.
	always_comb
	begin
		tx_flit.dest = tx_dest_i;
		tx_flit.src = MY_ROW;
		tx_flit.sop = tx_sop_i;
		tx_flit.eop = tx_eop_i;
		tx_flit.data = tx_data_i;
	end

	// The queue decouples user pushes from network arbitration; a full queue drops tx_ready_o.
	vnap_fifo #(
		.WIDTH(FLIT_W),
		.DEPTH(vnap_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(tx_valid_i),
		.in_data_i(tx_flit),
		.in_ready_o(tx_ready_o),
		.out_valid_o(loc_valid),
		.out_data_o(loc_flit),
		.out_ready_i(loc_pop)
	);

	assign loc_route = vnap_pkg::route_of(loc_flit.dest, MY_ROW);
	assign loc_self = loc_valid && (loc_route == vnap_pkg::VNAP_GO_LOCAL);

	genvar d;
	generate
		for (d = 0; d < DC; d++)
		begin : g_dir
			localparam vnap_pkg::vnap_route_type AWAY =
				(d == vnap_pkg::DIR_N) ? vnap_pkg::VNAP_GO_SOUTH : vnap_pkg::VNAP_GO_NORTH;
			// Words from the north travel south, so they follow the southward pattern.
			localparam logic [vnap_pkg::SCHED_W-1:0] SCHED_START = vnap_pkg::sched_init(
				(d == vnap_pkg::DIR_N) ? SOUTHWARD_PRIORITY_PATTERN : NORTHWARD_PRIORITY_PATTERN);
			logic hold_valid_d;

			// A word arriving for another row keeps travelling in its direction.
			assign hold_to_rx[d] = hold_valid_q[d] &&
				(vnap_pkg::route_of(hold_flit_q[d].dest, MY_ROW) == vnap_pkg::VNAP_GO_LOCAL);
			assign hold_pass[d] = hold_valid_q[d] && !hold_to_rx[d];
			assign loc_want[d] = loc_valid && (loc_route == AWAY);
			assign out_free[d] = !out_valid_q[d] || out_ready[d];
			assign contest[d] = loc_want[d] && hold_pass[d];
			assign grant_loc[d] = loc_want[d] && (!hold_pass[d] || sched_q[d][0]);
			assign loc_go[d] = grant_loc[d] && out_free[d];
			assign hold_pop[d] = (hold_pass[d] && !grant_loc[d] && out_free[d]) || rx_take_hold[d];

			always_comb
			begin
				hold_valid_d = hold_valid_q[d] && !hold_pop[d];
				if (up_valid[d] && hold_ready_q[d])
				begin
					hold_valid_d = 1'b1;
				end
			end

			// Single-entry landing stage keeps the upstream ready a plain flop output.
			always_ff @(posedge sys_clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					hold_valid_q[d] <= 1'b0;
					hold_ready_q[d] <= 1'b0;
				end
				else
				begin
					hold_valid_q[d] <= hold_valid_d;
					hold_ready_q[d] <= !hold_valid_d;
				end
			end

			always_ff @(posedge sys_clk_i)
			begin
				if (up_valid[d] && hold_ready_q[d])
				begin
					hold_flit_q[d] <= up_flit[d];
				end
			end

			// The pattern only moves when the contest is really resolved into the output stage.
			always_ff @(posedge sys_clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					sched_q[d] <= SCHED_START;
				end
				else if (contest[d] && out_free[d])
				begin
					sched_q[d] <= {sched_q[d][vnap_pkg::SCHED_W-2:0],
						sched_q[d][vnap_pkg::SCHED_W-1]};
				end
			end

			always_ff @(posedge sys_clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					out_valid_q[d] <= 1'b0;
				end
				else if (out_free[d])
				begin
					out_valid_q[d] <= loc_want[d] || hold_pass[d];
				end
			end

			always_ff @(posedge sys_clk_i)
			begin
				if (out_free[d])
				begin
					out_flit_q[d] <= grant_loc[d] ? loc_flit : hold_flit_q[d];
				end
			end
		end
	endgenerate

	assign loc_pop = (|loc_go) || rx_take_loc;
	assign rx_free = !rx_valid_q || rx_ready_i;

	// Arrivals for this row alternate between north and south; local loopback waits behind both.
	always_comb
	begin
		rx_take_hold = '0;
		rx_take_loc = 1'b0;
		rx_next = loc_flit;
		if (rx_free)
		begin
			if (hold_to_rx[vnap_pkg::DIR_N] && hold_to_rx[vnap_pkg::DIR_S])
			begin
				if (rx_rr_q)
				begin
					rx_take_hold[vnap_pkg::DIR_S] = 1'b1;
					rx_next = hold_flit_q[vnap_pkg::DIR_S];
				end
				else
				begin
					rx_take_hold[vnap_pkg::DIR_N] = 1'b1;
					rx_next = hold_flit_q[vnap_pkg::DIR_N];
				end
			end
			else if (hold_to_rx[vnap_pkg::DIR_N])
			begin
				rx_take_hold[vnap_pkg::DIR_N] = 1'b1;
				rx_next = hold_flit_q[vnap_pkg::DIR_N];
			end
			else if (hold_to_rx[vnap_pkg::DIR_S])
			begin
				rx_take_hold[vnap_pkg::DIR_S] = 1'b1;
				rx_next = hold_flit_q[vnap_pkg::DIR_S];
			end
			else if (loc_self)
			begin
				rx_take_loc = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_rr_q <= 1'b0;
		end
		else if (rx_free && (&hold_to_rx))
		begin
			rx_rr_q <= !rx_rr_q;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_valid_q <= 1'b0;
		end
		else if (rx_free)
		begin
			rx_valid_q <= (|rx_take_hold) || rx_take_loc;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rx_free)
		begin
			rx_flit_q <= rx_next;
		end
	end

	assign rx_valid_o = rx_valid_q;
	assign rx_src_o = rx_flit_q.src;
	assign rx_sop_o = rx_flit_q.sop;
	assign rx_eop_o = rx_flit_q.eop;
	assign rx_data_o = rx_flit_q.data;

	// Partial reconfiguration would drive this level; for now it is pinned low.
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_out_n_q <= vnap_pkg::RST_OUT_LEVEL;
		end
		else
		begin
			rst_out_n_q <= vnap_pkg::RST_OUT_LEVEL;
		end
	end

	assign rst_out_n_o = rst_out_n_q;

endmodule : vnap_access_point

/* logic/vnap_fifo.sv */
`timescale 1ns/1ps
// Flip-flop FIFO; DEPTH must be a power of two so the pointers wrap by themselves.
module vnap_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Filling side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Draining side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic in_ready_q;
	logic out_valid_q;
	logic push;
	logic pop;

	assign push = in_valid_i && in_ready_q;
	assign pop = out_valid_q && out_ready_i;
	assign in_ready_o = in_ready_q;
	assign out_valid_o = out_valid_q;
	assign out_data_o = mem_q[rd_q];

	always_comb
	begin
		cnt_d = cnt_q;
		if (push && !pop)
		begin
			cnt_d = cnt_q + 1'b1;
		end
		else if (pop && !push)
		begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop)
			begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	// Flags are registered from the next count so both handshake outputs come from flops.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= '0;
			in_ready_q <= 1'b0;
			out_valid_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			in_ready_q <= (cnt_d != FULL_COUNT);
			out_valid_q <= (cnt_d != '0);
		end
	end

endmodule : vnap_fifo

/* logic/vnap_pkg.sv */
package vnap_pkg;

	localparam int DATA_W = 293;
	localparam int ROW_W = 4;
	localparam int SCHED_W = 32;
	localparam int FIFO_DEPTH = 32;
	localparam int DIR_COUNT = 2;
	localparam int DIR_N = 0;
	localparam int DIR_S = 1;

	localparam logic [SCHED_W-1:0] SCHED_DEFAULT = 32'haaaa_aaaa;
	localparam logic [SCHED_W-1:0] SCHED_ILLEGAL = 32'hffff_ffff;
	localparam logic [ROW_W-1:0] ROW_DEFAULT = 4'h1;
	localparam logic RST_OUT_LEVEL = 1'h0;

	// One network word with its routing and framing fields.
	typedef struct packed {
		logic [ROW_W-1:0] dest;
		logic [ROW_W-1:0] src;
		logic sop;
		logic eop;
		logic [DATA_W-1:0] data;
	} vnap_flit_type;

	typedef enum logic [1:0] {
		VNAP_GO_LOCAL,
		VNAP_GO_NORTH,
		VNAP_GO_SOUTH
	} vnap_route_type;

	// An all-ones pattern would lock out upstream traffic, so it falls back to the default.
	function automatic logic [SCHED_W-1:0] sched_init(input logic [SCHED_W-1:0] pattern);
		if (pattern == SCHED_ILLEGAL)
		begin
			return SCHED_DEFAULT;
		end
		return pattern;
	endfunction : sched_init

	// Rows with a lower number lie to the north of this node.
	function automatic vnap_route_type route_of(input logic [ROW_W-1:0] dest,
		input logic [ROW_W-1:0] here);
		if (dest == here)
		begin
			return VNAP_GO_LOCAL;
		end
		else if (dest < here)
		begin
			return VNAP_GO_NORTH;
		end
		return VNAP_GO_SOUTH;
	endfunction : route_of

endpackage : vnap_pkg

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
	localparam logic [3:0] ROW = 4'h4;
	typedef vnap_pkg::vnap_flit_type vnap_f_type;
	logic sys_clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic [2:0] vld = 3'h0;
	vnap_f_type fl[3];
	logic [1:0] m_rx = 2'h0, m_s = 2'h0, m_n = 2'h0;
	logic rx_ready_i, to_south_ready_i, to_north_ready_i;
	logic rst_out_n_o, rx_valid_o, rx_sop_o, rx_eop_o, to_south_valid_o, to_north_valid_o;
	logic [2:0] rdy;
	logic [3:0] rx_src_o;
	logic [292:0] rx_data_o;
	vnap_f_type to_south_flit_o, to_north_flit_o, rx_seen;
	vnap_f_type exp_rx[$], exp_s[$], exp_n[$];
	vnap_f_type w;
	logic [3:0] dl[3] = '{4'h2, 4'h4, 4'h9};
	int seed = 78;
	int error_cnt = 0;
	int n_tests = 0;
	int k;

	vnap_access_point #(.MY_ROW(ROW), .SOUTHWARD_PRIORITY_PATTERN(32'h8888_8888),
		.NORTHWARD_PRIORITY_PATTERN(32'hffff_ffff)) dut (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .rst_out_n_o(rst_out_n_o),
		.tx_ready_o(rdy[0]), .tx_valid_i(vld[0]), .tx_dest_i(fl[0].dest),
		.tx_sop_i(fl[0].sop), .tx_eop_i(fl[0].eop), .tx_data_i(fl[0].data),
		.rx_ready_i(rx_ready_i), .rx_valid_o(rx_valid_o), .rx_src_o(rx_src_o),
		.rx_sop_o(rx_sop_o), .rx_eop_o(rx_eop_o), .rx_data_o(rx_data_o),
		.from_north_valid_i(vld[1]), .from_north_flit_i(fl[1]), .from_north_ready_o(rdy[1]),
		.from_south_valid_i(vld[2]), .from_south_flit_i(fl[2]), .from_south_ready_o(rdy[2]),
		.to_south_valid_o(to_south_valid_o), .to_south_flit_o(to_south_flit_o),
		.to_south_ready_i(to_south_ready_i), .to_north_valid_o(to_north_valid_o),
		.to_north_flit_o(to_north_flit_o), .to_north_ready_i(to_north_ready_i));
	vnap_sink u_rx (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .mode_i(m_rx), .ready_o(rx_ready_i));
	vnap_sink u_s (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .mode_i(m_s),
		.ready_o(to_south_ready_i));
	vnap_sink u_n (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .mode_i(m_n),
		.ready_o(to_north_ready_i));

	assign rx_seen = {ROW, rx_src_o, rx_sop_o, rx_eop_o, rx_data_o};

	initial
	begin
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [302:0] seen, input logic [302:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic guard(inout int n);
		n++;
		if (n > 3000)
		begin
			error_cnt++;
			end_sim();
		end
	endtask : guard

	function automatic vnap_f_type mk(input logic [3:0] d, input logic [3:0] s);
		vnap_f_type f;
		f.dest = d;
		f.src = s;
		f.sop = $random(seed);
		f.eop = $random(seed);
		for (int i = 0; i < 10; i++)
			f.data = {f.data[260:0], 32'($random(seed))};
		return f;
	endfunction : mk

	// The bench's routing model: lower rows lie north.
	function automatic void put(input vnap_f_type f);
		if (f.dest == ROW)
			exp_rx.push_back(f);
		else if (f.dest < ROW)
			exp_n.push_back(f);
		else
			exp_s.push_back(f);
	endfunction : put

	// Ready is a flop, so its value at the falling edge is the one the next rising edge sees.
	task automatic send(input int p, input vnap_f_type f);
		int n = 0;
		logic ok;
		@(negedge sys_clk_i);
		fl[p] = f;
		vld[p] = 1'h1;
		do
		begin
			ok = rdy[p];
			@(posedge sys_clk_i);
			guard(n);
		end while (ok !== 1'h1);
	endtask : send

	// A released port shows inverted fields so stale values cannot pass for valid ones.
	task automatic idle(input int p);
		@(negedge sys_clk_i);
		vld[p] = 1'h0;
		fl[p] = ~fl[p];
	endtask : idle

	task automatic drain();
		int n = 0;
		while (exp_rx.size() + exp_s.size() + exp_n.size() > 0)
		begin
			@(posedge sys_clk_i);
			guard(n);
		end
	endtask : drain

	task automatic arb(input int p, input logic [3:0] d, input logic [31:0] pat);
		vnap_f_type lq[$], uq[$], uc[$], f;
		logic [31:0] s = pat;
		if (p == 1)
			m_s = 2'h2;
		else
			m_n = 2'h2;
		f = mk(d, 4'h1);
		put(f);
		send(p, f);
		for (int i = 0; i < 12; i++)
			uq.push_back(mk(d, 4'h5));
		uc = uq;
		send(p, uc.pop_front());
		idle(p);
		for (int i = 0; i < 4; i++)
		begin
			lq.push_back(mk(d, ROW));
			send(0, lq[i]);
		end
		idle(0);
		while (lq.size() > 0 && uq.size() > 0)
		begin
			put(s[0] ? lq.pop_front() : uq.pop_front());
			s = {s[30:0], s[31]};
		end
		foreach (lq[i]) put(lq[i]);
		foreach (uq[i]) put(uq[i]);
		if (p == 1)
			m_s = 2'h1;
		else
			m_n = 2'h1;
		foreach (uc[i]) send(p, uc[i]);
		idle(p);
		drain();
		m_s = 2'h0;
		m_n = 2'h0;
	endtask : arb

	// Looked at mid-cycle: a word seen with valid and ready here moves at the next rising edge.
	always @(negedge sys_clk_i)
	begin
		if (rst_n_i && rx_valid_o && rx_ready_i)
			chk("rx", rx_seen, exp_rx.pop_front());
		if (rst_n_i && to_south_valid_o && to_south_ready_i)
			chk("south", to_south_flit_o, exp_s.pop_front());
		if (rst_n_i && to_north_valid_o && to_north_ready_i)
			chk("north", to_north_flit_o, exp_n.pop_front());
	end

	initial
	begin
		fl = '{default: '0};
		repeat (5) @(negedge sys_clk_i);
		rst_n_i = 1'h1;
		repeat (2) @(negedge sys_clk_i);
		chk("tx_ready", 303'(rdy[0]), 303'h1);
		m_rx = 2'h3;
		m_s = 2'h3;
		m_n = 2'h3;
		for (int i = 0; i < 24; i++)
		begin
			k = i % 3;
			w = mk(dl[k], ROW);
			put(w);
			send(0, w);
		end
		idle(0);
		drain();
		for (int i = 0; i < 12; i++)
		begin
			w = mk(i[0] ? 4'h9 : ROW, 4'h1);
			put(w);
			send(1, w);
			idle(1);
			w = mk(i[0] ? 4'h2 : ROW, 4'hc);
			put(w);
			send(2, w);
			idle(2);
		end
		idle(1);
		idle(2);
		drain();
		m_rx = 2'h2;
		k = 0;
		@(negedge sys_clk_i);
		vld[0] = 1'h1;
		fl[0] = mk(ROW, ROW);
		while (k < 40)
		begin
			if (rdy[0] !== 1'h1)
				break;
			@(posedge sys_clk_i);
			exp_rx.push_back(fl[0]);
			k++;
			@(negedge sys_clk_i);
			fl[0] = mk(ROW, ROW);
		end
		idle(0);
		chk("fill", 303'(k >= 32 && k <= 34), 303'h1);
		m_rx = 2'h1;
		drain();
		m_rx = 2'h0;
		arb(1, 4'h9, 32'h8888_8888);
		arb(2, 4'h2, 32'haaaa_aaaa);
		@(negedge sys_clk_i);
		rst_n_i = 1'h0;
		@(negedge sys_clk_i);
		chk("reset", 303'({rdy[0], rx_valid_o, rst_out_n_o}), 303'h0);
		rst_n_i = 1'h1;
		repeat (2) @(negedge sys_clk_i);
		end_sim();
	end
endmodule : tb

/* verif/vnap_access_point_sva.sv */
`timescale 1ns/1ps
module vnap_checker #(
	parameter logic [vnap_pkg::ROW_W-1:0] MY_ROW = vnap_pkg::ROW_DEFAULT
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Observed ports
	input wire logic rst_out_n_o,
	input wire logic tx_valid_i,
	input wire logic tx_ready_o,
	input wire logic rx_ready_i,
	input wire logic rx_valid_o,
	input wire logic [vnap_pkg::ROW_W-1:0] rx_src_o,
	input wire logic rx_sop_o,
	input wire logic rx_eop_o,
	input wire logic [vnap_pkg::DATA_W-1:0] rx_data_o,
	input wire logic from_north_valid_i,
	input wire logic from_north_ready_o,
	input wire logic to_south_valid_o,
	input wire vnap_pkg::vnap_flit_type to_south_flit_o,
	input wire logic to_south_ready_i,
	input wire logic to_north_valid_o,
	input wire vnap_pkg::vnap_flit_type to_north_flit_o,
	input wire logic to_north_ready_i
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_RST_OUT: assert property (rst_out_n_o == 1'h0)
		else $error("reset output not low");
	AST_S_HOLD: assert property (to_south_valid_o && !to_south_ready_i
		|=> to_south_valid_o && $stable(to_south_flit_o)) else $error("south word dropped");
	AST_N_HOLD: assert property (to_north_valid_o && !to_north_ready_i
		|=> to_north_valid_o && $stable(to_north_flit_o)) else $error("north word dropped");
	AST_RX_HOLD: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o
		&& $stable({rx_src_o, rx_sop_o, rx_eop_o, rx_data_o})) else $error("rx word dropped");
	AST_S_DEST: assert property (to_south_valid_o |-> to_south_flit_o.dest > MY_ROW)
		else $error("wrong row sent south");
	AST_N_DEST: assert property (to_north_valid_o |-> to_north_flit_o.dest < MY_ROW)
		else $error("wrong row sent north");
	AST_TX_FULL: assert property ($fell(tx_ready_o) |-> $past(tx_valid_i && tx_ready_o))
		else $error("tx ready fell without a take");
	AST_UP_ONE: assert property (from_north_valid_i && from_north_ready_o
		|=> !from_north_ready_o) else $error("upstream stage overtaken");
endmodule : vnap_checker

bind vnap_access_point vnap_checker #(.MY_ROW(MY_ROW)) u_chk (.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i), .rst_out_n_o(rst_out_n_o), .tx_valid_i(tx_valid_i),
	.tx_ready_o(tx_ready_o), .rx_ready_i(rx_ready_i), .rx_valid_o(rx_valid_o),
	.rx_src_o(rx_src_o), .rx_sop_o(rx_sop_o), .rx_eop_o(rx_eop_o), .rx_data_o(rx_data_o),
	.from_north_valid_i(from_north_valid_i), .from_north_ready_o(from_north_ready_o),
	.to_south_valid_o(to_south_valid_o), .to_south_flit_o(to_south_flit_o),
	.to_south_ready_i(to_south_ready_i), .to_north_valid_o(to_north_valid_o),
	.to_north_flit_o(to_north_flit_o), .to_north_ready_i(to_north_ready_i));

/* verif/vnap_sink.sv */
`timescale 1ns/1ps
// Far-side logic that takes words; it offers ready as set by mode_i, without modelling any room.
module vnap_sink (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Behaviour: 0 prompt, 1 slow, 2 stalled, 3 random
	input wire logic [1:0] mode_i,
	output logic ready_o
);
	logic [2:0] cnt_q;
	int seed = 78;

	always @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_q <= 3'h0;
		else
			cnt_q <= (cnt_q == 3'h5) ? 3'h0 : cnt_q + 3'h1;
	end

	// Slow mode gives one take in six cycles, long enough for upstream words to queue up.
	always @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ready_o <= 1'h0;
		else
			case (mode_i)
				2'h0: ready_o <= 1'h1;
				2'h1: ready_o <= (cnt_q == 3'h4);
				2'h2: ready_o <= 1'h0;
				default: ready_o <= $random(seed);
			endcase
	end
endmodule : vnap_sink
